// file: src/eifcr_edge_sync.sv
// module: pin synchroniser with single-cycle edge pulse
`timescale 1ns/1ns
module eifcr_edge_sync #(
	parameter bit RISING = 1'b1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// pin and pulse
	input wire logic pin_i,
	output logic edge_o
);

	// idle level avoids a false edge right after reset
	localparam bit IDLE = ~RISING;

	logic meta_reg, meta_next;
	logic sync_reg, sync_next;
	logic last_reg, last_next;
	logic edge_reg, edge_next;

	always_comb begin
		meta_next = pin_i;
		sync_next = meta_reg;
		last_next = sync_reg;
		if (RISING) begin
			edge_next = sync_reg & ~last_reg;
		end else begin
			edge_next = ~sync_reg & last_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= IDLE;
			sync_reg <= IDLE;
			last_reg <= IDLE;
			edge_reg <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			last_reg <= last_next;
			edge_reg <= edge_next;
		end
	end

	assign edge_o = edge_reg;

endmodule

// file: src/eifcr_pkg.sv
// package: register map, field layout and carriers of the flag block
//////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////
package eifcr_pkg;

	localparam int unsigned WB_AW = 8;
	localparam int unsigned WB_DW = 32;

	// register byte offsets
	localparam logic [7:0] REG_FLAG = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_IEN = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	localparam logic [7:0] REG_MASK = 8'h10;

	// external_irq_flag_clock_status fields
	localparam int unsigned FLG_FOUR = 6;
	localparam int unsigned FLG_THREE = 5;
	localparam int unsigned FLG_TWO = 4;
	localparam int unsigned FLG_READY = 3;
	localparam int unsigned FLG_RING_MODE = 2;
	localparam int unsigned FLG_RING_SEL = 1;

	// control fields
	localparam int unsigned CTL_MULT_EN = 0;
	localparam int unsigned CTL_DIV_LO = 1;
	localparam int unsigned CTL_DIV_HI = 2;
	localparam int unsigned CTL_MULT_SEL = 3;

	// source index inside enable and request vectors
	localparam int unsigned SRC_TWO = 0;
	localparam int unsigned SRC_THREE = 1;
	localparam int unsigned SRC_FOUR = 2;
	localparam int unsigned SRC_N = 3;

	// event status bits
	localparam int unsigned EV_READY = 0;
	localparam int unsigned EV_DIV_BLK = 1;
	localparam int unsigned EV_SEL_BLK = 2;
	localparam int unsigned EV_N = 3;

	// reset values
	localparam logic [2:0] RST_FLAGS = 3'h0;
	localparam logic [1:0] RST_DIV = 2'h0;
	localparam logic [2:0] RST_EVT = 3'h0;

	// warm-up length in core clocks
	localparam int unsigned WARMUP_COUNT = 65536;

	typedef enum logic [0:0] {
		WST_WARM = 1'b0,
		WST_READY = 1'b1
	} eifcr_warm_st_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [WB_AW-1:0] adr;
		logic [WB_DW-1:0] dat;
	} eifcr_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [WB_DW-1:0] dat;
	} eifcr_wb_rsp_t;

	typedef struct packed {
		logic mult_en;
		logic [1:0] divider;
		logic mult_sel;
		logic ring_active;
	} eifcr_clk_ctl_t;

endpackage

// file: src/eifcr_top.sv
// module: external edge flags and clock-ready guard behind wishbone
`timescale 1ns/1ns
module eifcr_top #(
	parameter int unsigned WARMUP_CYCLES = eifcr_pkg::WARMUP_COUNT
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire eifcr_pkg::eifcr_wb_req_t wb_i,
	output eifcr_pkg::eifcr_wb_rsp_t wb_o,
	// interrupt pins and power state
	input wire logic irq_pin_two_i,
	input wire logic irq_pin_three_i,
	input wire logic irq_pin_four_i,
	input wire logic stop_exit_i,
	// requests, clock control, interrupt
	output logic [eifcr_pkg::SRC_N-1:0] irq_req_o,
	output eifcr_pkg::eifcr_clk_ctl_t clk_ctl_o,
	output logic clock_ready_o,
	output logic irq_o
);
	import eifcr_pkg::*;

	//////////////////////////////////////////////////////////////////
	// pin edges and warm-up

	logic [SRC_N-1:0] pin_edge;
	logic ready;
	logic restart;

	eifcr_edge_sync #(.RISING(1'b1)) u_edge_two (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(irq_pin_two_i),
		.edge_o(pin_edge[SRC_TWO])
	);

	eifcr_edge_sync #(.RISING(1'b0)) u_edge_three (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(irq_pin_three_i),
		.edge_o(pin_edge[SRC_THREE])
	);

	eifcr_edge_sync #(.RISING(1'b1)) u_edge_four (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(irq_pin_four_i),
		.edge_o(pin_edge[SRC_FOUR])
	);

	eifcr_warmup #(.CYCLES(WARMUP_CYCLES)) u_warmup (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.restart_i(restart),
		.ready_o(ready)
	);

	//////////////////////////////////////////////////////////////////
	// bus decode

	logic ack_reg, ack_next;
	logic [WB_DW-1:0] dat_reg, dat_next;
	logic req, wr;
	logic wr_flag, wr_ctrl, wr_ien, wr_stat, wr_mask;
	logic [7:0] wbyte;
	logic [7:0] rbyte;

	// one answer per request; the gap after ack keeps it single
	assign req = wb_i.cyc & wb_i.stb & ~ack_reg;
	assign wr = req & wb_i.we & wb_i.sel[0];
	assign wbyte = wb_i.dat[7:0];
	assign wr_flag = wr & (wb_i.adr == REG_FLAG);
	assign wr_ctrl = wr & (wb_i.adr == REG_CTRL);
	assign wr_ien = wr & (wb_i.adr == REG_IEN);
	assign wr_stat = wr & (wb_i.adr == REG_STAT);
	assign wr_mask = wr & (wb_i.adr == REG_MASK);

	//////////////////////////////////////////////////////////////////
	// register state

	logic [SRC_N-1:0] flag_reg, flag_next;
	logic ring_sel_reg, ring_sel_next;
	logic ring_act_reg, ring_act_next;
	logic mult_en_reg, mult_en_next;
	logic [1:0] div_reg, div_next;
	logic mult_sel_reg, mult_sel_next;
	logic [SRC_N-1:0] ien_reg, ien_next;
	logic [SRC_N-1:0] ireq_reg, ireq_next;
	logic [EV_N-1:0] stat_reg, stat_next;
	logic [EV_N-1:0] mask_reg, mask_next;
	logic irq_reg, irq_next;
	logic ready_q_reg, ready_q_next;
	logic [EV_N-1:0] ev;
	logic [1:0] wdiv;

	assign wdiv = wbyte[CTL_DIV_HI:CTL_DIV_LO];
	// restart on stop exit or on a 0 to 1 write of the multiplier enable
	assign restart = stop_exit_i |
		(wr_ctrl & wbyte[CTL_MULT_EN] & ~mult_en_reg);

	always_comb begin
		ev = '0;
		// edge sets win over a clearing write in the same cycle
		flag_next = flag_reg;
		if (wr_flag) begin
			flag_next = {wbyte[FLG_FOUR], wbyte[FLG_THREE],
				wbyte[FLG_TWO]};
		end
		flag_next = flag_next | pin_edge;
		ring_sel_next = wr_flag ? wbyte[FLG_RING_SEL] : ring_sel_reg;
		ring_act_next = ring_sel_reg & ~ready;
		mult_en_next = wr_ctrl ? wbyte[CTL_MULT_EN] : mult_en_reg;
		div_next = div_reg;
		mult_sel_next = mult_sel_reg;
		if (wr_ctrl) begin
			if (ready) begin
				div_next = wdiv;
			end else if (wdiv != div_reg) begin
				ev[EV_DIV_BLK] = 1'b1;
			end
			if (ready) begin
				mult_sel_next = wbyte[CTL_MULT_SEL];
			end else if (wbyte[CTL_MULT_SEL]) begin
				ev[EV_SEL_BLK] = 1'b1;
			end
		end
		// an unwarmed multiplier must not stay the source
		if (!ready) begin
			mult_sel_next = 1'b0;
		end
		ien_next = wr_ien ? wbyte[SRC_N-1:0] : ien_reg;
		ireq_next = flag_reg & ien_reg;
		ready_q_next = ready;
		ev[EV_READY] = ready & ~ready_q_reg;
		stat_next = stat_reg;
		if (wr_stat) begin
			stat_next = stat_reg & ~wbyte[EV_N-1:0];
		end
		stat_next = stat_next | ev;
		mask_next = wr_mask ? wbyte[EV_N-1:0] : mask_reg;
		irq_next = |(stat_reg & mask_reg);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_reg <= RST_FLAGS;
			ring_sel_reg <= 1'b0;
			ring_act_reg <= 1'b0;
			mult_en_reg <= 1'b0;
			div_reg <= RST_DIV;
			mult_sel_reg <= 1'b0;
			ien_reg <= RST_FLAGS;
			ireq_reg <= RST_FLAGS;
			stat_reg <= RST_EVT;
			mask_reg <= RST_EVT;
			irq_reg <= 1'b0;
			ready_q_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
			ring_sel_reg <= ring_sel_next;
			ring_act_reg <= ring_act_next;
			mult_en_reg <= mult_en_next;
			div_reg <= div_next;
			mult_sel_reg <= mult_sel_next;
			ien_reg <= ien_next;
			ireq_reg <= ireq_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			irq_reg <= irq_next;
			ready_q_reg <= ready_q_next;
		end
	end

	//////////////////////////////////////////////////////////////////
	// read path and ack

	always_comb begin
		rbyte = 8'h00;
		case (wb_i.adr)
			REG_FLAG: begin
				rbyte[FLG_FOUR] = flag_reg[SRC_FOUR];
				rbyte[FLG_THREE] = flag_reg[SRC_THREE];
				rbyte[FLG_TWO] = flag_reg[SRC_TWO];
				rbyte[FLG_READY] = ready;
				rbyte[FLG_RING_MODE] = ring_act_reg;
				rbyte[FLG_RING_SEL] = ring_sel_reg;
			end
			REG_CTRL: begin
				rbyte[CTL_MULT_EN] = mult_en_reg;
				rbyte[CTL_DIV_HI:CTL_DIV_LO] = div_reg;
				rbyte[CTL_MULT_SEL] = mult_sel_reg;
			end
			REG_IEN: begin
				rbyte[SRC_N-1:0] = ien_reg;
			end
			REG_STAT: begin
				rbyte[EV_N-1:0] = stat_reg;
			end
			REG_MASK: begin
				rbyte[EV_N-1:0] = mask_reg;
			end
			default: begin
				rbyte = 8'h00;
			end
		endcase
		ack_next = req;
		dat_next = req ? {24'h000000, rbyte} : dat_reg;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end else begin
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	assign wb_o.ack = ack_reg;
	assign wb_o.dat = dat_reg;
	assign irq_req_o = ireq_reg;
	assign clk_ctl_o.mult_en = mult_en_reg;
	assign clk_ctl_o.divider = div_reg;
	assign clk_ctl_o.mult_sel = mult_sel_reg;
	assign clk_ctl_o.ring_active = ring_act_reg;
	assign clock_ready_o = ready;
	assign irq_o = irq_reg;

	//////////////////////////////////////////////////////////////////
	// checks

	// counts low cycles of the ready flag since the last restart
	int unsigned low_cnt_reg, low_cnt_next;

	always_comb begin
		low_cnt_next = (ready | restart) ? 0 : low_cnt_reg + 1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_cnt_reg <= 0;
		end else begin
			low_cnt_reg <= low_cnt_next;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_flag_four;
		pin_edge[SRC_FOUR] |=> flag_reg[SRC_FOUR];
	endproperty
	a_flag_four: assert property (p_flag_four)
		else $error("edge flag four not set by pin edge");

	property p_flag_three;
		$fell(irq_pin_three_i) ##3 pin_edge[SRC_THREE]
			|=> flag_reg[SRC_THREE];
	endproperty
	a_flag_three: assert property (p_flag_three)
		else $error("edge flag three not set by falling pin");

	property p_flag_two;
		$rose(irq_pin_two_i) |-> ##3 pin_edge[SRC_TWO] ##1 flag_reg[SRC_TWO];
	endproperty
	a_flag_two: assert property (p_flag_two)
		else $error("edge flag two not set by rising pin");

	property p_no_self_clear;
		(|($past(flag_reg) & ~flag_reg)) |-> $past(wr_flag);
	endproperty
	a_no_self_clear: assert property (p_no_self_clear)
		else $error("edge flag cleared without a write");

	property p_sw_set_req;
		wr_flag && wbyte[FLG_FOUR] && ien_reg[SRC_FOUR]
			|-> ##2 irq_req_o[SRC_FOUR];
	endproperty
	a_sw_set_req: assert property (p_sw_set_req)
		else $error("software set flag raised no request");

	property p_stop_clear;
		stop_exit_i |=> !clock_ready_o;
	endproperty
	a_stop_clear: assert property (p_stop_clear)
		else $error("ready not cleared on stop exit");

	property p_mult_clear;
		wr_ctrl && wbyte[CTL_MULT_EN] && !mult_en_reg
			|=> !clock_ready_o && clk_ctl_o.mult_en;
	endproperty
	a_mult_clear: assert property (p_mult_clear)
		else $error("ready not cleared on multiplier enable");

	property p_warm_len;
		$rose(clock_ready_o) |-> low_cnt_reg == WARMUP_CYCLES;
	endproperty
	a_warm_len: assert property (p_warm_len)
		else $error("warm-up length wrong");

	property p_div_lock;
		wr_ctrl && !clock_ready_o
			|=> clk_ctl_o.divider == $past(clk_ctl_o.divider);
	endproperty
	a_div_lock: assert property (p_div_lock)
		else $error("divider changed while clock not ready");

	property p_sel_ready;
		clk_ctl_o.mult_sel |-> $past(clock_ready_o);
	endproperty
	a_sel_ready: assert property (p_sel_ready)
		else $error("multiplier selected before clock ready");

	property p_ring_run;
		ring_sel_reg && !clock_ready_o |=> clk_ctl_o.ring_active;
	endproperty
	a_ring_run: assert property (p_ring_run)
		else $error("ring oscillator not running during warm-up");

	property p_one_pulse;
		pin_edge[SRC_FOUR] |=> !pin_edge[SRC_FOUR] [*2];
	endproperty
	a_one_pulse: assert property (p_one_pulse)
		else $error("one pin edge gave several pulses");

	c_pin_flag: cover property (pin_edge[SRC_TWO] ##1 flag_reg[SRC_TWO]);
	c_ready: cover property ($rose(clock_ready_o));
	c_div_blk: cover property (stat_reg[EV_DIV_BLK]);
	c_irq: cover property ($rose(irq_o));

endmodule

// file: src/eifcr_warmup.sv
// module: warm-up counter behind the clock-ready flag
`timescale 1ns/1ns
module eifcr_warmup
	import eifcr_pkg::*;
#(
	parameter int unsigned CYCLES = 65536
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control and status
	input wire logic restart_i,
	output logic ready_o
);

	localparam int unsigned CW = $clog2(CYCLES);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	eifcr_warm_st_t st_reg, st_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic ready_reg, ready_next;

	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		case (st_reg)
			WST_WARM: begin
				if (cnt_reg == LAST) begin
					st_next = WST_READY;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			WST_READY: begin
				cnt_next = '0;
			end
			default: begin
				st_next = WST_WARM;
			end
		endcase
		if (restart_i) begin
			st_next = WST_WARM;
			cnt_next = '0;
		end
		ready_next = (st_next == WST_READY);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= WST_WARM;
			cnt_reg <= '0;
			ready_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			ready_reg <= ready_next;
		end
	end

	assign ready_o = ready_reg;

endmodule

// file: verif/eifcr_pin_model.sv
// partner model: outside interrupt sources driving the three pins
`timescale 1ns/1ns
module eifcr_pin_model (
	// clock
	input wire logic clk_i,
	// pulse request, bit0 two, bit1 three, bit2 four
	input wire logic [2:0] fire_i,
	// pins
	output logic irq_pin_two_o,
	output logic irq_pin_three_o,
	output logic irq_pin_four_o
);
	int cnt [3] = '{0, 0, 0};
	always @(posedge clk_i) begin
		for (int k = 0; k < 3; k++) begin
			if (fire_i[k]) begin
				cnt[k] <= 3;
			end else if (cnt[k] > 0) begin
				cnt[k] <= cnt[k] - 1;
			end
		end
	end
	// active level held three cycles, more than the synchroniser needs
	assign irq_pin_two_o = cnt[0] > 0;
	assign irq_pin_three_o = !(cnt[1] > 0);
	assign irq_pin_four_o = cnt[2] > 0;
endmodule

// file: verif/tb.sv
// testbench: edge flags, warm-up guard and register bus
`timescale 1ns/1ns
module tb;
	import eifcr_pkg::*;
	localparam int unsigned WU = 16;
	typedef struct packed {
		logic [7:0] adr;
		logic [7:0] wdat;
		logic [7:0] rdat;
		logic [2:0] req;
	} eifcr_row_t;
	eifcr_row_t rows [6] = '{
		'{REG_IEN, 8'h07, 8'h07, 3'h0},
		'{REG_FLAG, 8'h70, 8'h78, 3'h7},
		'{REG_FLAG, 8'h20, 8'h28, 3'h2},
		'{REG_FLAG, 8'h00, 8'h08, 3'h0},
		'{REG_MASK, 8'h06, 8'h06, 3'h0},
		'{8'h14, 8'hFF, 8'h00, 3'h0}
	};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	eifcr_wb_req_t wb_i = '0;
	eifcr_wb_rsp_t wb_o;
	logic irq_pin_two_i, irq_pin_three_i, irq_pin_four_i;
	logic stop_exit_i = 1'b0;
	logic [2:0] fire = 3'h0;
	logic [SRC_N-1:0] irq_req_o;
	eifcr_clk_ctl_t clk_ctl_o;
	logic clock_ready_o, irq_o;
	logic [31:0] rd;
	// byte enables of the next bus cycle; one case drops sel[0]
	logic [3:0] wsel = 4'hF;
	int fail_count = 0;
	int total_checks = 0;

	eifcr_top #(.WARMUP_CYCLES(WU)) i_eifcr_top (.clk_i(clk_i),
		.rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
		.irq_pin_two_i(irq_pin_two_i), .irq_pin_three_i(irq_pin_three_i),
		.irq_pin_four_i(irq_pin_four_i), .stop_exit_i(stop_exit_i),
		.irq_req_o(irq_req_o), .clk_ctl_o(clk_ctl_o),
		.clock_ready_o(clock_ready_o), .irq_o(irq_o));
	eifcr_pin_model i_eifcr_pin_model (.clk_i(clk_i), .fire_i(fire),
		.irq_pin_two_o(irq_pin_two_i), .irq_pin_three_o(irq_pin_three_i),
		.irq_pin_four_o(irq_pin_four_i));

	initial begin
		forever #10 clk_i = ~clk_i;
	end
	//////////////////////////////////////////////////////////////////
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// single classic cycle; no fixed latency assumed, watchdog ends a hang
	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] dat);
		@(posedge clk_i);
		wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: wsel, adr: adr,
			dat: dat};
		do begin
			@(posedge clk_i);
		end while (wb_o.ack !== 1'b1);
		rd = wb_o.dat;
		wb_i <= '0;
	endtask
	task automatic reset_and_warm();
		int k = 0;
		rst_i <= 1'b1;
		wait_clk(8);
		rst_i <= 1'b0;
		chk_bit(clock_ready_o, 1'b0);
		do begin
			@(posedge clk_i);
			k++;
		end while (clock_ready_o !== 1'b1 && k < 200);
		chk_word(k, 32'(WU + 1));
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////
	initial begin
		wait_clk(5000);
		fail_count++;
		wrap_up();
	end
	initial begin
		reset_and_warm();
		$display("test reset done");
		foreach (rows[i]) begin
			wb(1'b1, rows[i].adr, {24'h0, rows[i].wdat});
			wb(1'b0, rows[i].adr, 32'h0);
			chk_word(rd, {24'h0, rows[i].rdat});
			chk_word({29'h0, irq_req_o}, {29'h0, rows[i].req});
		end
		$display("test table done");
		// interrupt: ready event raised, masked, cleared
		wb(1'b1, REG_MASK, 32'h01);
		wait_clk(2);
		chk_bit(irq_o, 1'b1);
		wb(1'b1, REG_MASK, 32'h00);
		wait_clk(2);
		chk_bit(irq_o, 1'b0);
		wb(1'b1, REG_MASK, 32'h01);
		wb(1'b1, REG_STAT, 32'h01);
		wait_clk(2);
		chk_bit(irq_o, 1'b0);
		$display("test interrupt done");
		// multiplier enable restarts warm-up and locks the divider
		wb(1'b1, REG_CTRL, 32'h01);
		wait_clk(1);
		chk_bit(clock_ready_o, 1'b0);
		wb(1'b1, REG_CTRL, 32'h0F);
		wait_clk(1);
		chk_word({27'h0, clk_ctl_o}, 32'h10);
		wb(1'b0, REG_STAT, 32'h0);
		chk_word(rd, 32'h06);
		wait_clk(WU + 2);
		wb(1'b1, REG_STAT, 32'h07);
		wb(1'b1, REG_CTRL, 32'h0F);
		wait_clk(1);
		chk_word({27'h0, clk_ctl_o}, 32'h1E);
		$display("test lock done");
		// stop exit with ring select: ring runs until ready
		wb(1'b1, REG_FLAG, 32'h02);
		stop_exit_i <= 1'b1;
		wait_clk(1);
		stop_exit_i <= 1'b0;
		wait_clk(2);
		chk_bit(clock_ready_o, 1'b0);
		chk_word({27'h0, clk_ctl_o}, 32'h1D);
		wait_clk(WU + 2);
		chk_word({27'h0, clk_ctl_o}, 32'h1C);
		$display("test stop exit done");
		// each pin pulse sets its own flag once
		for (int k = 0; k < 3; k++) begin
			fire <= 3'h1 << k;
			wait_clk(1);
			fire <= 3'h0;
			wait_clk(12);
			wb(1'b0, REG_FLAG, 32'h0);
			chk_word(rd, 32'h0A | (32'h10 << k));
			wb(1'b1, REG_FLAG, 32'h02);
			wait_clk(12);
			wb(1'b0, REG_FLAG, 32'h0);
			chk_word(rd, 32'h0A);
		end
		$display("test pins done");
		// a write without the low byte enable must leave the register alone
		wsel = 4'hE;
		wb(1'b1, REG_IEN, 32'h00);
		wsel = 4'hF;
		wb(1'b0, REG_IEN, 32'h0);
		chk_word(rd, 32'h07);
		$display("test byte enable done");
		// reset in mid-run
		wb(1'b1, REG_FLAG, 32'h00);
		reset_and_warm();
		wb(1'b0, REG_CTRL, 32'h0);
		chk_word(rd, 32'h00);
		$display("test second reset done");
		wrap_up();
	end
endmodule
